/* File: core/atarch_defines.svh */
`ifndef ATARCH_DEFINES_SVH
`define ATARCH_DEFINES_SVH

// opcodes
`define ATARCH_OP_RDBUF 8'he4
`define ATARCH_OP_RDBUF_DMA 8'he9
`define ATARCH_OP_RDDMA 8'hc8
`define ATARCH_OP_RDDMA_HI 7'h64

// taskfile register addresses
`define ATARCH_TF_DATA 3'h0
`define ATARCH_TF_ERR 3'h1
`define ATARCH_TF_CNT 3'h2
`define ATARCH_TF_SECT 3'h3
`define ATARCH_TF_CYLL 3'h4
`define ATARCH_TF_CYLH 3'h5
`define ATARCH_TF_DEVH 3'h6
`define ATARCH_TF_CMD 3'h7

// status bits
`define ATARCH_ST_BSY 7
`define ATARCH_ST_RDY 6
`define ATARCH_ST_DF 5
`define ATARCH_ST_DSC 4
`define ATARCH_ST_DRQ 3
`define ATARCH_ST_COR 2
`define ATARCH_ST_ERR 0
`define ATARCH_ST_READY 8'h50
`define ATARCH_ST_BUSY 8'hd0

// error bits
`define ATARCH_ER_UNC 6
`define ATARCH_ER_ABT 2

// addressing-mode bit within device/head bits 7:4
`define ATARCH_DEVH_L_TOP 2

// sector framing and counts
`define ATARCH_SEC_WORDS 256
`define ATARCH_WORD_LAST 8'hff
`define ATARCH_ONE_SECTOR 9'h001
`define ATARCH_MAX_SECTORS 9'h100

// chs stepping geometry
`define ATARCH_CHS_SPT 8'h3f
`define ATARCH_CHS_FIRST_SEC 8'h01
`define ATARCH_CHS_LAST_HEAD 4'hf

// completion notice
`define ATARCH_SDB_ACT_TAG0 32'h0000_0001

// staging fifo
`define ATARCH_FIFO_WIDTH 16
`define ATARCH_FIFO_DEPTH 32

`endif

/* File: core/atarch_pkg.sv */
package atarch_pkg;

   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_xfer = 2'b01,
      st_done = 2'b11
   } atarch_state_t;

   typedef enum logic [1:0] {
      cmd_pio_buf = 2'b00,
      cmd_dma_buf = 2'b01,
      cmd_dma_read = 2'b10,
      cmd_bad = 2'b11
   } atarch_cmd_t;

   typedef struct packed {
      atarch_state_t state;
      atarch_cmd_t cmd;
      logic lba;
      logic [3:0] devh_top;
      logic [7:0] count;
      logic [27:0] cur_addr;
      logic [7:0] err;
      logic [7:0] stat;
      logic intrq;
      logic [15:0] rdata;
      logic [27:0] src_addr;
      logic [8:0] src_left;
      logic [7:0] src_word;
      logic [8:0] dst_left;
      logic [7:0] dst_word;
      logic unc;
      logic [15:0] hold;
      logic hold_vld;
      logic dmarq;
      logic media_req;
      logic sdb;
      logic [31:0] sdb_act;
   } atarch_regs_t;

endpackage

/* File: core/atarch_fifo.sv */
`timescale 1ns/10ps

module atarch_fifo
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
)
(
   input wire logic i_clock,
   input wire logic i_srst,
   input wire logic i_valid,
   input wire logic [WIDTH-1:0] i_data,
   output logic o_ready,
   output logic o_valid,
   output logic [WIDTH-1:0] o_data,
   input wire logic i_ready
);
   localparam int AW = $clog2(DEPTH);

   // depth must be a power of two so the pointers wrap on their own
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic rdy;
   } atarch_fifo_st_t;

   atarch_fifo_st_t s_ff;
   atarch_fifo_st_t nxt_s;
   logic push;
   logic pop;

   assign push = i_valid & s_ff.rdy;
   assign pop = o_valid & i_ready;
   assign o_ready = s_ff.rdy;
   assign o_valid = (s_ff.cnt != '0);
   assign o_data = s_ff.mem[s_ff.rp];

   always_comb
   begin
      nxt_s = s_ff;
      if (push)
      begin
         nxt_s.mem[s_ff.wp] = i_data;
         nxt_s.wp = AW'(s_ff.wp + 1'b1);
      end
      if (pop)
      begin
         nxt_s.rp = AW'(s_ff.rp + 1'b1);
      end
      case ({push, pop})
         2'b10: nxt_s.cnt = (AW+1)'(s_ff.cnt + 1'b1);
         2'b01: nxt_s.cnt = (AW+1)'(s_ff.cnt - 1'b1);
         default: nxt_s.cnt = s_ff.cnt;
      endcase
      // ready is registered so the filling side sees a clean flop
      nxt_s.rdy = (nxt_s.cnt != (AW+1)'(DEPTH));
   end

   always_ff @(posedge i_clock)
   begin
      if (i_srst)
      begin
         s_ff <= '0;
         s_ff.rdy <= 1'b1;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

endmodule

/* File: core/atarch_top.sv */
`timescale 1ns/10ps
`include "atarch_defines.svh"

module atarch_top
(
   input wire logic i_clock,
   input wire logic i_srst,
   input wire logic i_tf_wr,
   input wire logic i_tf_rd,
   input wire logic [2:0] i_tf_addr,
   input wire logic [7:0] i_tf_wdata,
   output logic [15:0] o_tf_rdata,
   output logic o_intrq,
   output logic o_dmarq,
   input wire logic i_dmack,
   output logic [15:0] o_dma_data,
   output logic o_media_req,
   output logic [27:0] o_media_addr,
   output logic o_media_lba,
   input wire logic i_media_valid,
   input wire logic [15:0] i_media_data,
   input wire logic i_media_unc,
   output logic o_media_ready,
   input wire logic i_bufw_en,
   input wire logic [7:0] i_bufw_addr,
   input wire logic [15:0] i_bufw_data,
   output logic o_sdb,
   output logic [31:0] o_sdb_act
);
   atarch_pkg::atarch_regs_t r_ff;
   atarch_pkg::atarch_regs_t nxt_r;
   logic [15:0] buf_mem [0:`ATARCH_SEC_WORDS-1];

   logic in_xfer;
   logic is_dma;
   logic is_media;
   logic src_go;
   logic fifo_in_valid;
   logic [15:0] fifo_in_data;
   logic fifo_ready;
   logic fifo_out_valid;
   logic [15:0] fifo_out_data;
   logic fifo_pop_rdy;
   logic push;
   logic take;
   logic load;
   logic pio_rd_data;
   logic drq;
   logic [7:0] st_view;
   logic finish;

   // one sector step; chs walks sector, then head, then cylinder
   function automatic logic [27:0] next_addr(input logic [27:0] a, input logic lba);
      logic [7:0] sec;
      logic [15:0] cyl;
      logic [3:0] hd;
      sec = a[7:0];
      cyl = a[23:8];
      hd = a[27:24];
      if (lba)
      begin
         return 28'(a + 28'h1);
      end
      if (sec != `ATARCH_CHS_SPT)
      begin
         sec = 8'(sec + 8'h01);
      end
      else
      begin
         sec = `ATARCH_CHS_FIRST_SEC;
         if (hd != `ATARCH_CHS_LAST_HEAD)
         begin
            hd = 4'(hd + 4'h1);
         end
         else
         begin
            hd = 4'h0;
            cyl = 16'(cyl + 16'h0001);
         end
      end
      return {hd, cyl, sec};
   endfunction

   function automatic atarch_pkg::atarch_cmd_t cmd_of(input logic [7:0] op);
      if (op == `ATARCH_OP_RDBUF)
      begin
         return atarch_pkg::cmd_pio_buf;
      end
      if (op == `ATARCH_OP_RDBUF_DMA)
      begin
         return atarch_pkg::cmd_dma_buf;
      end
      if (op[7:1] == `ATARCH_OP_RDDMA_HI)
      begin
         return atarch_pkg::cmd_dma_read;
      end
      return atarch_pkg::cmd_bad;
   endfunction

   // media traffic never refreshes this array; contents are kept as is
   always_ff @(posedge i_clock)
   begin
      if (i_bufw_en)
      begin
         buf_mem[i_bufw_addr] <= i_bufw_data;
      end
   end

   assign in_xfer = (r_ff.state == atarch_pkg::st_xfer);
   assign is_dma = (r_ff.cmd != atarch_pkg::cmd_pio_buf);
   assign is_media = (r_ff.cmd == atarch_pkg::cmd_dma_read);
   assign src_go = in_xfer & (r_ff.src_left != 9'h000) & ~r_ff.unc;
   // media words enter only while a fetch is requested
   assign fifo_in_valid = is_media ? (r_ff.media_req & i_media_valid) : src_go;
   assign fifo_in_data = is_media ? i_media_data : buf_mem[r_ff.src_word];
   assign push = fifo_in_valid & fifo_ready;
   assign pio_rd_data = i_tf_rd & (i_tf_addr == `ATARCH_TF_DATA) & in_xfer;
   // a dma word moves only on acknowledge while dmarq is up
   assign take = r_ff.hold_vld & (is_dma ? (i_dmack & r_ff.dmarq) : pio_rd_data);
   assign fifo_pop_rdy = in_xfer & (~r_ff.hold_vld | take);
   assign load = fifo_out_valid & fifo_pop_rdy;
   assign drq = in_xfer & ~is_dma & r_ff.hold_vld;
   assign st_view = r_ff.stat | ({7'h00, drq} << `ATARCH_ST_DRQ);
   // after a bad sector only whole sectors already fetched drain out
   assign finish = (r_ff.unc | (r_ff.src_left == 9'h000)) & (r_ff.dst_left == r_ff.src_left)
      & (r_ff.dst_word == 8'h00) & ~r_ff.hold_vld & ~fifo_out_valid;

   atarch_fifo
   #(
      .WIDTH(`ATARCH_FIFO_WIDTH),
      .DEPTH(`ATARCH_FIFO_DEPTH)
   )
   u_fifo
   (
      .i_clock(i_clock),
      .i_srst(i_srst),
      .i_valid(fifo_in_valid),
      .i_data(fifo_in_data),
      .o_ready(fifo_ready),
      .o_valid(fifo_out_valid),
      .o_data(fifo_out_data),
      .i_ready(fifo_pop_rdy)
   );

   always_comb
   begin
      nxt_r = r_ff;
      nxt_r.sdb = 1'b0;
      nxt_r.sdb_act = 32'h0000_0000;
      if (i_tf_rd)
      begin
         case (i_tf_addr)
            `ATARCH_TF_DATA: nxt_r.rdata = take ? r_ff.hold : 16'h0000;
            `ATARCH_TF_ERR: nxt_r.rdata = {8'h00, r_ff.err};
            `ATARCH_TF_CNT: nxt_r.rdata = {8'h00, r_ff.count};
            `ATARCH_TF_SECT: nxt_r.rdata = {8'h00, r_ff.cur_addr[7:0]};
            `ATARCH_TF_CYLL: nxt_r.rdata = {8'h00, r_ff.cur_addr[15:8]};
            `ATARCH_TF_CYLH: nxt_r.rdata = {8'h00, r_ff.cur_addr[23:16]};
            `ATARCH_TF_DEVH: nxt_r.rdata = {8'h00, r_ff.devh_top, r_ff.cur_addr[27:24]};
            default:
            begin
               nxt_r.rdata = {8'h00, st_view};
               // status read acknowledges the interrupt; a new set below wins
               nxt_r.intrq = 1'b0;
            end
         endcase
      end
      case (r_ff.state)
         atarch_pkg::st_idle:
         begin
            if (i_tf_wr)
            begin
               case (i_tf_addr)
                  `ATARCH_TF_CNT: nxt_r.count = i_tf_wdata;
                  `ATARCH_TF_SECT: nxt_r.cur_addr[7:0] = i_tf_wdata;
                  `ATARCH_TF_CYLL: nxt_r.cur_addr[15:8] = i_tf_wdata;
                  `ATARCH_TF_CYLH: nxt_r.cur_addr[23:16] = i_tf_wdata;
                  `ATARCH_TF_DEVH:
                  begin
                     nxt_r.devh_top = i_tf_wdata[7:4];
                     nxt_r.cur_addr[27:24] = i_tf_wdata[3:0];
                  end
                  `ATARCH_TF_CMD:
                  begin
                     // host dma channel is assumed armed before this write
                     nxt_r.cmd = cmd_of(i_tf_wdata);
                     nxt_r.lba = r_ff.devh_top[`ATARCH_DEVH_L_TOP];
                     nxt_r.err = 8'h00;
                     nxt_r.stat = `ATARCH_ST_BUSY;
                     nxt_r.intrq = 1'b0;
                     nxt_r.src_word = 8'h00;
                     nxt_r.dst_word = 8'h00;
                     nxt_r.unc = 1'b0;
                     nxt_r.src_addr = r_ff.cur_addr;
                     nxt_r.state = atarch_pkg::st_xfer;
                     case (cmd_of(i_tf_wdata))
                        atarch_pkg::cmd_dma_read:
                        begin
                           nxt_r.src_left = (r_ff.count == 8'h00) ? `ATARCH_MAX_SECTORS
                              : {1'b0, r_ff.count};
                        end
                        atarch_pkg::cmd_bad:
                        begin
                           nxt_r.src_left = 9'h000;
                           nxt_r.err[`ATARCH_ER_ABT] = 1'b1;
                           nxt_r.state = atarch_pkg::st_done;
                        end
                        default:
                        begin
                           nxt_r.src_left = `ATARCH_ONE_SECTOR;
                        end
                     endcase
                     nxt_r.dst_left = nxt_r.src_left;
                  end
                  default:
                  begin
                     nxt_r.rdata = r_ff.rdata;
                  end
               endcase
            end
         end
         atarch_pkg::st_xfer:
         begin
            if (push)
            begin
               nxt_r.src_word = 8'(r_ff.src_word + 8'h01);
               if (r_ff.src_word == `ATARCH_WORD_LAST)
               begin
                  nxt_r.src_left = 9'(r_ff.src_left - 9'h001);
                  nxt_r.src_addr = next_addr(r_ff.src_addr, r_ff.lba);
               end
            end
            // stop fetching at the failing sector
            if (r_ff.media_req & i_media_unc)
            begin
               nxt_r.unc = 1'b1;
               nxt_r.err[`ATARCH_ER_UNC] = 1'b1;
            end
            if (load)
            begin
               nxt_r.hold = fifo_out_data;
               nxt_r.hold_vld = 1'b1;
            end
            else if (take)
            begin
               nxt_r.hold_vld = 1'b0;
            end
            // one word per transfer to the host
            if (take)
            begin
               nxt_r.dst_word = 8'(r_ff.dst_word + 8'h01);
               if (r_ff.dst_word == `ATARCH_WORD_LAST)
               begin
                  nxt_r.dst_left = 9'(r_ff.dst_left - 9'h001);
                  // address stays on the last delivered sector
                  // advance only if another sector can still follow, so a cut read keeps the last good one
                  if (is_media && ((9'(r_ff.dst_left - 9'h001) != r_ff.src_left)
                     || (!r_ff.unc && !(r_ff.media_req && i_media_unc) && (r_ff.src_left != 9'h000))))
                  begin
                     nxt_r.cur_addr = next_addr(r_ff.cur_addr, r_ff.lba);
                  end
               end
            end
            if (finish)
            begin
               nxt_r.state = atarch_pkg::st_done;
            end
         end
         atarch_pkg::st_done:
         begin
            // busy, fault, corrected cleared; error follows causes
            nxt_r.stat = `ATARCH_ST_READY | ({7'h00, |r_ff.err} << `ATARCH_ST_ERR);
            nxt_r.count = r_ff.dst_left[7:0];
            // single interrupt, with status already settled
            nxt_r.intrq = 1'b1;
            // completion notice only for a dma read (c8/c9) that finished without error
            if (is_media && (r_ff.err == 8'h00))
            begin
               nxt_r.sdb = 1'b1;
               nxt_r.sdb_act = `ATARCH_SDB_ACT_TAG0;
            end
            nxt_r.state = atarch_pkg::st_idle;
         end
         default:
         begin
            nxt_r.state = atarch_pkg::st_idle;
         end
      endcase
      // request stands exactly while a word is held for dma
      nxt_r.dmarq = (nxt_r.state == atarch_pkg::st_xfer) & (nxt_r.cmd != atarch_pkg::cmd_pio_buf)
         & nxt_r.hold_vld;
      // fetch request only while sectors remain and no bad sector
      nxt_r.media_req = (nxt_r.state == atarch_pkg::st_xfer) & (nxt_r.cmd == atarch_pkg::cmd_dma_read)
         & (nxt_r.src_left != 9'h000) & ~nxt_r.unc;
   end

   always_ff @(posedge i_clock)
   begin
      if (i_srst)
      begin
         r_ff <= '0;
         r_ff.stat <= `ATARCH_ST_READY;
      end
      else
      begin
         r_ff <= nxt_r;
      end
   end

   assign o_tf_rdata = r_ff.rdata;
   assign o_intrq = r_ff.intrq;
   assign o_dmarq = r_ff.dmarq;
   assign o_dma_data = r_ff.hold;
   assign o_media_req = r_ff.media_req;
   assign o_media_addr = r_ff.src_addr;
   assign o_media_lba = r_ff.lba;
   assign o_media_ready = fifo_ready;
   assign o_sdb = r_ff.sdb;
   assign o_sdb_act = r_ff.sdb_act;

   logic cmd_wr;
   logic [7:0] dst_left_lo;
   logic devh_l;
   assign cmd_wr = i_tf_wr && (i_tf_addr == `ATARCH_TF_CMD) && (r_ff.state == atarch_pkg::st_idle);
   assign dst_left_lo = r_ff.dst_left[7:0];
   assign devh_l = r_ff.devh_top[`ATARCH_DEVH_L_TOP];

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_srst);

   sequence s_issue(logic [7:0] op);
      cmd_wr && (i_tf_wdata == op);
   endsequence

   sequence s_finish;
      (r_ff.state == atarch_pkg::st_done) ##1 (o_intrq && !r_ff.stat[`ATARCH_ST_BSY]);
   endsequence

   property p_rdbuf_pio;
      s_issue(`ATARCH_OP_RDBUF) |=> (r_ff.cmd == atarch_pkg::cmd_pio_buf)
         && (r_ff.dst_left == `ATARCH_ONE_SECTOR) && in_xfer && !o_dmarq;
   endproperty
   a_rdbuf_pio: assert property (p_rdbuf_pio) else $error("e4 did not start one pio sector");

   property p_rdbuf_dma;
      s_issue(`ATARCH_OP_RDBUF_DMA) |=> (r_ff.cmd == atarch_pkg::cmd_dma_buf)
         && (r_ff.dst_left == `ATARCH_ONE_SECTOR) && in_xfer;
   endproperty
   a_rdbuf_dma: assert property (p_rdbuf_dma) else $error("e9 did not start one dma sector");

   property p_word_step;
      take && (r_ff.dst_word != `ATARCH_WORD_LAST) |=> (r_ff.dst_word == 8'($past(r_ff.dst_word) + 8'h01));
   endproperty
   a_word_step: assert property (p_word_step) else $error("word count did not step by one");

   property p_retry_ignored;
      cmd_wr && (i_tf_wdata[7:1] == `ATARCH_OP_RDDMA_HI) |=> (r_ff.cmd == atarch_pkg::cmd_dma_read);
   endproperty
   a_retry_ignored: assert property (p_retry_ignored) else $error("c8/c9 not taken as dma read");

   property p_dmarq_gate;
      o_dmarq |-> in_xfer && is_dma && r_ff.hold_vld;
   endproperty
   a_dmarq_gate: assert property (p_dmarq_gate) else $error("dmarq without a held word");

   property p_no_move_idle;
      i_dmack && !o_dmarq && is_dma |=> $stable(r_ff.dst_word);
   endproperty
   a_no_move_idle: assert property (p_no_move_idle) else $error("word moved without dmarq");

   property p_single_intr;
      $rose(o_intrq) |-> $past(r_ff.state == atarch_pkg::st_done);
   endproperty
   a_single_intr: assert property (p_single_intr) else $error("interrupt outside command end");

   property p_intr_follows;
      (r_ff.state == atarch_pkg::st_done) |-> s_finish;
   endproperty
   a_intr_follows: assert property (p_intr_follows) else $error("no interrupt after status");

   property p_unc_halt;
      r_ff.unc && in_xfer |=> $stable(r_ff.src_left) && !o_media_req;
   endproperty
   a_unc_halt: assert property (p_unc_halt) else $error("fetch continued past bad sector");

   property p_count_zero;
      s_issue(`ATARCH_OP_RDDMA) && (r_ff.count == 8'h00) |=> (r_ff.dst_left == `ATARCH_MAX_SECTORS);
   endproperty
   a_count_zero: assert property (p_count_zero) else $error("zero count not 256 sectors");

   property p_start_addr;
      cmd_wr ##1 is_media |-> (r_ff.src_addr == $past(r_ff.cur_addr)) && (r_ff.lba == $past(devh_l));
   endproperty
   a_start_addr: assert property (p_start_addr) else $error("start address not from taskfile");

   property p_remaining;
      (r_ff.state == atarch_pkg::st_done) |=> (r_ff.count == $past(dst_left_lo));
   endproperty
   a_remaining: assert property (p_remaining) else $error("count not left with remainder");

   property p_end_status;
      (r_ff.state == atarch_pkg::st_done) |=> !r_ff.stat[`ATARCH_ST_BSY] && !r_ff.stat[`ATARCH_ST_DF]
         && !r_ff.stat[`ATARCH_ST_COR] && (r_ff.stat[`ATARCH_ST_ERR] == (|r_ff.err));
   endproperty
   a_end_status: assert property (p_end_status) else $error("end status bits wrong");

   property p_sdb;
      (r_ff.state == atarch_pkg::st_done) && is_media && (r_ff.err == 8'h00)
         |=> o_sdb && (o_sdb_act == `ATARCH_SDB_ACT_TAG0);
   endproperty
   a_sdb: assert property (p_sdb) else $error("missing completion notice");

endmodule

/* File: tb/atarch_host_dma.sv */
`timescale 1ns/10ps
module atarch_host_dma
(
   input wire logic i_armed,
   input wire logic i_dmarq,
   input wire logic [15:0] i_data,
   input wire logic i_stall,
   output logic o_dmack,
   output logic o_got,
   output logic [15:0] o_word
);
   // nothing is acknowledged until the channel is armed
   // a word moves only under request; stray acks without it probe the refusal
   assign o_dmack = i_armed & (i_dmarq ? ~i_stall : i_stall);
   assign o_got = o_dmack & i_dmarq;
   assign o_word = i_data;
endmodule

/* File: tb/ata_read_command_handler_tb.sv */
`timescale 1ns/10ps
`include "atarch_defines.svh"
module ata_read_command_handler_tb;
   logic i_clock, i_srst, wr, rd, dmack, mvld, munc, bwen, req, mrdy, intrq, dmarq, got, stall;
   logic armed, mlba, sdb;
   logic [2:0] ta;
   logic [7:0] wd, ba;
   logic [15:0] rdat, ddat, mdat, bd, word, d;
   logic [27:0] maddr;
   logic [15:0] bufm [256];
   logic [15:0] exp_q [$];
   logic [31:0] rnd, srnd, act;
   int fail_count, num_checks, i, n;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   atarch_top u_dut (.i_clock(i_clock), .i_srst(i_srst), .i_tf_wr(wr), .i_tf_rd(rd), .i_tf_addr(ta),
      .i_tf_wdata(wd), .o_tf_rdata(rdat), .o_intrq(intrq), .o_dmarq(dmarq), .i_dmack(dmack),
      .o_dma_data(ddat), .o_media_req(req), .o_media_addr(maddr), .o_media_lba(mlba), .i_media_valid(mvld),
      .i_media_data(mdat), .i_media_unc(munc), .o_media_ready(mrdy), .i_bufw_en(bwen), .i_bufw_addr(ba),
      .i_bufw_data(bd), .o_sdb(sdb), .o_sdb_act(act));
   atarch_host_dma u_host (.i_armed(armed), .i_dmarq(dmarq), .i_data(ddat), .i_stall(stall), .o_dmack(dmack),
      .o_got(got), .o_word(word));
   initial
   begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end
   task automatic chk(input logic [15:0] e, input logic [15:0] a);
      num_checks++;
      if (a !== e)
      begin
         fail_count++;
         $display("[ERR] %0t expected %h got %h", $time, e, a);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic hang(input int n);
      if (n >= 40000)
      begin
         fail_count++;
         $display("[ERR] %0t wait ran out", $time);
         end_sim();
      end
   endtask
   task automatic tf_w(input logic [2:0] a, input logic [7:0] v);
      @(negedge i_clock) wr = 1'b1;
      ta = a;
      wd = v;
      @(negedge i_clock) wr = 1'b0;
   endtask
   task automatic tf_r(input logic [2:0] a);
      @(negedge i_clock) rd = 1'b1;
      ta = a;
      @(negedge i_clock) rd = 1'b0;
      d = rdat;
   endtask
   task automatic rd8(input logic [2:0] a, input logic [7:0] e);
      tf_r(a);
      chk({8'h00, e}, {8'h00, d[7:0]});
   endtask
   task automatic wait_intrq(input bit es);
      int n;
      for (n = 0; n < 40000 && intrq !== 1'b1; n++) @(negedge i_clock);
      hang(n);
      chk(16'h0000, 16'(exp_q.size()));
      // the notice pulses in the same cycle as the interrupt rises
      chk({15'h0000, es}, {15'h0000, sdb});
      chk({15'h0000, es}, act[15:0]);
      chk(16'h0000, act[31:16]);
   endtask
   // command with taskfile setup, then first fetch address
   task automatic go(input logic [7:0] op, cnt, sn, cl, ch, dh, input logic [27:0] ea, input bit el);
      int n;
      tf_w(3'h2, cnt);
      tf_w(3'h3, sn);
      tf_w(3'h4, cl);
      tf_w(3'h5, ch);
      tf_w(3'h6, dh);
      tf_w(3'h7, op);
      for (n = 0; n < 40000 && req !== 1'b1; n++) @(negedge i_clock);
      hang(n);
      chk(ea[15:0], maddr[15:0]);
      chk({4'h0, ea[27:16]}, {4'h0, maddr[27:16]});
      chk({15'h0000, el}, {15'h0000, mlba});
   endtask
   task automatic feed(input int nsec, input bit unc);
      int w, k;
      w = 0;
      for (k = 0; w < nsec * 256 && k < 40000; k++)
      begin
         @(negedge i_clock) mvld = 1'b1;
         mdat = rnd[15:0];
         // request and ready are flops: what stands here is what the next edge samples
         if (req === 1'b1 && mrdy === 1'b1)
         begin
            exp_q.push_back(mdat);
            w++;
            rnd = lfsr(rnd);
         end
      end
      hang(k);
      @(negedge i_clock) mvld = 1'b0;
      munc = unc;
      @(negedge i_clock) munc = 1'b0;
   endtask
   // random host stalls keep the staging fifo filling up
   always @(negedge i_clock)
   begin
      srnd = lfsr(srnd);
      stall = srnd[0];
   end
   always @(posedge i_clock)
      if (got === 1'b1)
      begin
         if (exp_q.size() == 0)
            chk(16'h0000, 16'h0001);
         else
            chk(exp_q.pop_front(), word);
      end
   initial
   begin
      {i_srst, wr, rd, mvld, munc, bwen, armed} = 7'h40;
      {ta, wd, ba, mdat, bd} = '0;
      {fail_count, num_checks} = '0;
      rnd = 32'h8b4c;
      srnd = 32'h8b4c;
      repeat (10) @(negedge i_clock);
      i_srst = 1'b0;
      rd8(3'h7, `ATARCH_ST_READY);
      for (i = 0; i < 256; i++)
      begin
         @(negedge i_clock) bwen = 1'b1;
         ba = i[7:0];
         bd = rnd[15:0];
         bufm[i] = rnd[15:0];
         rnd = lfsr(rnd);
      end
      @(negedge i_clock) bwen = 1'b0;
      for (i = 0; i < 256; i++) exp_q.push_back(bufm[i]);
      // channel armed before the first dma opcode
      armed = 1'b1;
      tf_w(3'h7, `ATARCH_OP_RDBUF_DMA);
      wait_intrq(1'b0);
      rd8(3'h7, `ATARCH_ST_READY);
      tf_w(3'h7, `ATARCH_OP_RDBUF);
      for (i = 0; i < 256; i++)
      begin
         // a fresh status read each word, so data bits never stand in for the drq flag
         tf_r(3'h7);
         for (n = 0; n < 40 && d[3] !== 1'b1; n++) tf_r(3'h7);
         hang(n * 1000);
         tf_r(3'h0);
         chk(bufm[i], d);
      end
      wait_intrq(1'b0);
      rd8(3'h7, `ATARCH_ST_READY);
      go(8'hc9, 8'h02, 8'h10, 8'h22, 8'h33, 8'he5, 28'h5332210, 1'b1);
      feed(2, 1'b0);
      wait_intrq(1'b1);
      rd8(3'h2, 8'h00);
      rd8(3'h3, 8'h11);
      rd8(3'h7, `ATARCH_ST_READY);
      go(8'hc8, 8'h03, 8'h05, 8'h01, 8'h00, 8'ha2, 28'h2000105, 1'b0);
      feed(1, 1'b1);
      wait_intrq(1'b0);
      rd8(3'h2, 8'h02);
      rd8(3'h1, 8'h40);
      rd8(3'h3, 8'h05);
      rd8(3'h7, 8'h51);
      // an opcode outside the set is aborted
      tf_w(3'h7, 8'h30);
      wait_intrq(1'b0);
      rd8(3'h1, 8'h04);
      rd8(3'h7, 8'h51);
      end_sim();
   end
endmodule
